// ### hw/paired_timer_control.sv
// Paired 16-bit timers joinable to 32 bits, with a classic Wishbone slave
`timescale 1ns/1ps
`include "paired_timer_regs.svh"
// Operation
// - The join bit of timer A makes both timers one 32-bit timer, else two 16-bit timers.
// - While joined, timer B control bits have no effect on the combined timer.
// - Timer A clock select 0 picks the internal clock, 1 picks the extended source field.
// - A control write while that timer runs resets its prescale counter.
// - With idle stop set the timer halts in Idle mode, else it keeps running.
// - The extended source picks low-power RC for 10, external pin for 01, secondary osc for 00.
// - The prescale field divides by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// - Timer B clock select 1 counts external pin rising edges, 0 the internal clock.
// - Unimplemented control bits ignore writes and read as zero.
module paired_timer_control
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Timer clock sources and device state
  input  wire logic        tick_int_i,
  input  wire logic        secondary_osc_i,
  input  wire logic        low_power_rc_osc_i,
  input  wire logic        timer_a_ext_clock_pin_i,
  input  wire logic        timer_b_ext_clock_pin_i,
  input  wire logic        gate_a_i,
  input  wire logic        gate_b_i,
  input  wire logic        idle_i,
  // Status
  output logic             join_wide_select_o,
  output logic             wrap_a_o,
  output logic             wrap_b_o
);
  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  // Pins from other domains: two flops, then a third for edges; the low-power RC gets three flops, then a fourth
  logic [4:0] s1_ff;
  logic [4:0] s2_ff;
  logic [4:0] s3_ff;
  logic [4:0] pin_in;
  logic [4:0] rise;
  assign pin_in = {gate_b_i, gate_a_i, timer_b_ext_clock_pin_i,
                   timer_a_ext_clock_pin_i, secondary_osc_i};
  logic [1:0] lp_s1_ff;
  logic [1:0] lp_s2_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_ff    <= 5'h00;
      s2_ff    <= 5'h00;
      s3_ff    <= 5'h00;
      lp_s1_ff <= 2'h0;
      lp_s2_ff <= 2'h0;
    end
    else
    begin
      s1_ff    <= pin_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      lp_s1_ff <= {lp_s1_ff[0], low_power_rc_osc_i};
      lp_s2_ff <= {lp_s2_ff[0], lp_s1_ff[1]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_edge
      assign rise[g] = s2_ff[g] && !s3_ff[g];
    end
  endgenerate
  assign rise[4] = 1'b0;
  // Bit 0 holds the newer sample: a rise is new high over old low
  logic low_rc_rise;
  assign low_rc_rise = lp_s2_ff[0] && !lp_s2_ff[1];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] ctrl_a_ff;
  logic [15:0] ctrl_b_ff;
  logic [15:0] cnt_a_ff;
  logic [15:0] cnt_b_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        wrap_a_ff;
  logic        wrap_b_ff;

  logic        req;
  logic        wr;
  logic        lo_en;
  logic        hi_en;
  logic        wr_ca;
  logic        wr_cb;
  logic [15:0] wval;
  logic [15:0] nxt_ctrl_a;
  logic [15:0] nxt_ctrl_b;
  logic [31:0] rd_mux;

  assign req   = cyc_i && stb_i && !ack_ff;
  assign wr    = req && we_i;
  assign lo_en = sel_i[0];
  assign hi_en = sel_i[1];
  assign wr_ca = wr && (adr_i == `TMR_A_CTRL_OFS);
  assign wr_cb = wr && (adr_i == `TMR_B_CTRL_OFS);

  // Byte lanes merged per register, masked to implemented bits
  assign wval       = {hi_en ? dat_i[15:8] : 8'h00, lo_en ? dat_i[7:0] : 8'h00};
  assign nxt_ctrl_a = (((ctrl_a_ff & ~{{8{hi_en}}, {8{lo_en}}}) | wval)
                       & `TMR_A_CTRL_MASK);
  assign nxt_ctrl_b = (((ctrl_b_ff & ~{{8{hi_en}}, {8{lo_en}}}) | wval)
                       & `TMR_B_CTRL_MASK);

  assign rd_mux = (adr_i == `TMR_A_CTRL_OFS)  ? {16'h0000, ctrl_a_ff} :
                  (adr_i == `TMR_B_CTRL_OFS)  ? {16'h0000, ctrl_b_ff} :
                  (adr_i == `TMR_A_COUNT_OFS) ? {16'h0000, cnt_a_ff}  :
                  (adr_i == `TMR_B_COUNT_OFS) ? {16'h0000, cnt_b_ff}  : 32'h0000_0000;

  // ----------------------------------------
  // Clock selection and gating
  // ----------------------------------------
  logic joined;
  logic run_a;
  logic run_b;
  logic src_a;
  logic src_b;
  logic ext_a_pick;
  paired_timer_pkg::ext_src_t ecs_a;

  assign joined = ctrl_a_ff[`TMR_JOIN_BIT];
  assign ecs_a  = paired_timer_pkg::ext_src_t'(ctrl_a_ff[`TMR_ECS_HI:`TMR_ECS_LO]);
  assign ext_a_pick = (ecs_a == paired_timer_pkg::ECS_LOW_RC)  ? low_rc_rise :
                      (ecs_a == paired_timer_pkg::ECS_EXT_PIN) ? rise[1]   :
                      (ecs_a == paired_timer_pkg::ECS_SECONDARY) ? rise[0] : 1'b0;

  // Idle stop and run gate each timer
  assign run_a = ctrl_a_ff[`TMR_RUN_BIT] && !(idle_i && ctrl_a_ff[`TMR_IDLE_STOP_BIT]);
  assign run_b = ctrl_b_ff[`TMR_RUN_BIT] && !(idle_i && ctrl_b_ff[`TMR_IDLE_STOP_BIT]);

  // Gate applies only with the internal clock selected
  assign src_a = run_a && (ctrl_a_ff[`TMR_CS_BIT] ? ext_a_pick :
                 (tick_int_i && (!ctrl_a_ff[`TMR_GATE_BIT] || s2_ff[3])));
  assign src_b = run_b && !joined && (ctrl_b_ff[`TMR_CS_BIT] ? rise[2] :
                 (tick_int_i && (!ctrl_b_ff[`TMR_GATE_BIT] || s2_ff[4])));

  // ----------------------------------------
  // Prescalers
  // ----------------------------------------
  tick_if tk_a ();
  tick_if tk_b ();
  assign tk_a.src_tick = src_a;
  assign tk_a.clr      = wr_ca && ctrl_a_ff[`TMR_RUN_BIT];
  assign tk_a.ps       = paired_timer_pkg::prescale_t'(ctrl_a_ff[`TMR_PS_HI:`TMR_PS_LO]);
  assign tk_b.src_tick = src_b;
  assign tk_b.clr      = wr_cb && ctrl_b_ff[`TMR_RUN_BIT];
  assign tk_b.ps       = paired_timer_pkg::prescale_t'(ctrl_b_ff[`TMR_PS_HI:`TMR_PS_LO]);

  timer_prescaler u_pre_a
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tk    (tk_a.pre)
  );
  timer_prescaler u_pre_b
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tk    (tk_b.pre)
  );

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic inc_a;
  logic inc_b;
  logic a_wrap;
  assign inc_a  = tk_a.out_tick;
  assign a_wrap = inc_a && (cnt_a_ff == 16'hFFFF);
  assign inc_b  = joined ? a_wrap : tk_b.out_tick;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_a_ff <= `TMR_CTRL_RESET;
      ctrl_b_ff <= `TMR_CTRL_RESET;
      cnt_a_ff  <= `TMR_COUNT_RESET;
      cnt_b_ff  <= `TMR_COUNT_RESET;
      ack_ff    <= 1'b0;
      dat_ff    <= 32'h0000_0000;
      wrap_a_ff <= 1'b0;
      wrap_b_ff <= 1'b0;
    end
    else
    begin
      ack_ff    <= req;
      dat_ff    <= req ? rd_mux : 32'h0000_0000;
      wrap_a_ff <= a_wrap;
      wrap_b_ff <= inc_b && (cnt_b_ff == 16'hFFFF);
      if (wr_ca)
        ctrl_a_ff <= nxt_ctrl_a;
      if (wr_cb)
        ctrl_b_ff <= nxt_ctrl_b;
      if (wr && (adr_i == `TMR_A_COUNT_OFS))
        cnt_a_ff <= (cnt_a_ff & ~{{8{hi_en}}, {8{lo_en}}}) | wval;
      else if (inc_a)
        cnt_a_ff <= cnt_a_ff + 16'h0001;
      if (wr && (adr_i == `TMR_B_COUNT_OFS))
        cnt_b_ff <= (cnt_b_ff & ~{{8{hi_en}}, {8{lo_en}}}) | wval;
      else if (inc_b)
        cnt_b_ff <= cnt_b_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic join_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      join_ff <= 1'b0;
    else
      join_ff <= joined;
  end
  assign join_wide_select_o = join_ff;
  assign ack_o    = ack_ff;
  assign dat_o    = dat_ff;
  assign wrap_a_o = wrap_a_ff;
  assign wrap_b_o = wrap_b_ff;
endmodule : paired_timer_control

// ### hw/paired_timer_regs.svh
// Register offsets, field positions, writable masks and reset values for the paired timer
`ifndef PAIRED_TIMER_REGS_SVH
`define PAIRED_TIMER_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TMR_A_CTRL_OFS     4'h0
`define TMR_B_CTRL_OFS     4'h4
`define TMR_A_COUNT_OFS    4'h8
`define TMR_B_COUNT_OFS    4'hC
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TMR_RUN_BIT        15
`define TMR_IDLE_STOP_BIT  13
`define TMR_ECS_HI         9
`define TMR_ECS_LO         8
`define TMR_GATE_BIT       6
`define TMR_PS_HI          5
`define TMR_PS_LO          4
`define TMR_JOIN_BIT       3
`define TMR_CS_BIT         1
// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define TMR_A_CTRL_MASK    16'hA37A
`define TMR_B_CTRL_MASK    16'hA372
`define TMR_CTRL_RESET     16'h0000
`define TMR_COUNT_RESET    16'h0000
`endif

// ### hw/paired_timer_pkg.sv
// Types shared by the paired timer files
package paired_timer_pkg;
  typedef enum logic [1:0]
  {
    ECS_SECONDARY = 2'b00,
    ECS_EXT_PIN   = 2'b01,
    ECS_LOW_RC    = 2'b10,
    ECS_RSVD      = 2'b11
  } ext_src_t;
  typedef enum logic [1:0]
  {
    PS_DIV1   = 2'b00,
    PS_DIV8   = 2'b01,
    PS_DIV64  = 2'b10,
    PS_DIV256 = 2'b11
  } prescale_t;
endpackage : paired_timer_pkg

// ### hw/tick_if.sv
// Carrier between timer control and its prescaler stage
`timescale 1ns/1ps
interface tick_if;
  logic                          src_tick;
  logic                          clr;
  paired_timer_pkg::prescale_t   ps;
  logic                          out_tick;
  modport ctrl (output src_tick, output clr, output ps, input out_tick);
  modport pre  (input src_tick, input clr, input ps, output out_tick);
endinterface : tick_if

// ### hw/timer_prescaler.sv
// Input prescaler: divides a tick stream by 1, 8, 64 or 256
`timescale 1ns/1ps
`include "paired_timer_regs.svh"
module timer_prescaler
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Tick carrier
  tick_if.pre       tk
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] limit;
  logic       hit;

  assign limit = (tk.ps == paired_timer_pkg::PS_DIV256) ? 8'hFF :
                 (tk.ps == paired_timer_pkg::PS_DIV64)  ? 8'h3F :
                 (tk.ps == paired_timer_pkg::PS_DIV8)   ? 8'h07 : 8'h00;
  assign hit     = tk.src_tick && (cnt_ff >= limit);
  assign nxt_cnt = tk.clr ? 8'h00 : hit ? 8'h00 : tk.src_tick ? cnt_ff + 8'h01 : cnt_ff;
  assign tk.out_tick = hit && !tk.clr;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule : timer_prescaler

// ### tb/paired_timer_control_assertions.sv
// Port-level checks for the paired timer control block
`timescale 1ns/1ps
`include "paired_timer_regs.svh"
module paired_timer_control_assertions
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone slave
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Status
  input wire logic        join_wide_select_o,
  input wire logic        wrap_a_o,
  input wire logic        wrap_b_o
);
  wire take = cyc_i & stb_i & ~ack_o;
  wire rd_a = ack_o & ~we_i & (adr_i == `TMR_A_CTRL_OFS);
  wire rd_b = ack_o & ~we_i & (adr_i == `TMR_B_CTRL_OFS);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answers: assert property (take |=> ack_o) else $error("no ack after request");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!take |=> !ack_o) else $error("ack without request");
  a_idle_data_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
  a_upper_half_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0)
    else $error("upper half not zero");
  a_mask_timer_a: assert property (rd_a |-> (dat_o[15:0] & ~`TMR_A_CTRL_MASK) == 16'h0)
    else $error("timer A unused bit set");
  a_mask_timer_b: assert property (rd_b |-> (dat_o[15:0] & ~`TMR_B_CTRL_MASK) == 16'h0)
    else $error("timer B unused bit set");
  a_join_follows: assert property (take && we_i && sel_i[0] && adr_i == `TMR_A_CTRL_OFS
    |-> ##2 join_wide_select_o == $past(dat_i[3], 2)) else $error("join output wrong");
  a_wrap_a_pulse: assert property ($rose(wrap_a_o) |=> !wrap_a_o) else $error("wrap A too long");
  a_wrap_b_pulse: assert property (wrap_b_o |=> !wrap_b_o) else $error("wrap B too long");
endmodule : paired_timer_control_assertions

bind paired_timer_control paired_timer_control_assertions chk_u (.*);

// ### tb/paired_timer_control_bench.sv
// Self-checking bench for the paired timer control block
`timescale 1ns/1ps
module paired_timer_control_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, rd;
  logic [4:0]  srcv = 5'h00;
  logic        gate_a_i = 1'b0, gate_b_i = 1'b0, idle_i = 1'b0;
  wire         tick_int_i, secondary_osc_i, timer_a_ext_clock_pin_i;
  wire         low_power_rc_osc_i, timer_b_ext_clock_pin_i;
  wire  [31:0] dat_o;
  wire         ack_o, join_wide_select_o, wrap_a_o, wrap_b_o;
  int          n_fail = 0, checks_done = 0, cycles = 0;
  int          wraps_a = 0, wraps_b = 0;
  assign {timer_b_ext_clock_pin_i, low_power_rc_osc_i, timer_a_ext_clock_pin_i,
          secondary_osc_i, tick_int_i} = srcv;
  always #4 clk_i = ~clk_i;
  paired_timer_control dut_u (.*);
  // Hang guard, well above the roughly 2300 cycles of the run
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (!rst_i)
    begin
      wraps_a <= wraps_a + wrap_a_o;
      wraps_b <= wraps_b + wrap_b_o;
    end
    if (cycles == 30000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Ack is read before the edge's own updates land
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 4'h3, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // Pins get 4-cycle halves so the input synchronisers see every edge
  task automatic pulses(input int s, input int n);
    int h;
    h = (s == 0) ? 1 : 4;
    repeat (n)
    begin
      srcv <= srcv | (5'h01 << s);
      repeat (h) @(posedge clk_i);
      srcv <= srcv & ~(5'h01 << s);
      repeat (h) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask : pulses
  task automatic run(input logic [3:0] a, input logic [15:0] c, input logic [1:0] ig,
                     input int s, input int n, input logic [15:0] init, input logic [15:0] e);
    {idle_i, gate_b_i} <= ig;
    wb(1'b1, a, 4'h3, {16'h0, c});
    wb(1'b1, a + 4'h8, 4'h3, {16'h0, init});
    pulses(s, n);
    rdchk(a + 4'h8, {16'h0, e});
    wb(1'b1, a, 4'h3, 32'h0);
    $display("case %h control %h done", a, c);
  endtask : run
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(4'h0, 32'h0);
    wb(1'b1, 4'h0, 4'hF, 32'hFFFFFFFF);
    rdchk(4'h0, 32'h0000A37A);
    wb(1'b1, 4'h4, 4'h2, 32'hFFFFFFFF);
    rdchk(4'h4, 32'h0000A300);
    wb(1'b1, 4'h2, 4'h3, 32'hFFFFFFFF);
    rdchk(4'h2, 32'h0);
    wb(1'b1, 4'h0, 4'h3, 32'h0);
    wb(1'b1, 4'h4, 4'h3, 32'h0);
    $display("register case done");
    run(4'h4, 16'h8000, 2'b00, 0, 16, 16'h0, 16'h10);
    run(4'h4, 16'h8010, 2'b00, 0, 64, 16'h0, 16'h8);
    run(4'h4, 16'h8020, 2'b00, 0, 128, 16'h0, 16'h2);
    run(4'h4, 16'h8030, 2'b00, 0, 512, 16'h0, 16'h2);
    run(4'h4, 16'h0000, 2'b00, 0, 16, 16'h0, 16'h0);
    run(4'h4, 16'hA000, 2'b10, 0, 16, 16'h0, 16'h0);
    run(4'h4, 16'h8000, 2'b10, 0, 16, 16'hFFF8, 16'h8);
    run(4'h4, 16'h8040, 2'b00, 0, 16, 16'h0, 16'h0);
    run(4'h4, 16'h8040, 2'b01, 0, 16, 16'h0, 16'h10);
    run(4'h4, 16'h8042, 2'b00, 4, 5, 16'h0, 16'h5);
    run(4'h4, 16'h8002, 2'b00, 0, 16, 16'h0, 16'h0);
    run(4'h0, 16'h8002, 2'b00, 1, 5, 16'h0, 16'h5);
    run(4'h0, 16'h8102, 2'b00, 2, 5, 16'h0, 16'h5);
    run(4'h0, 16'h8202, 2'b00, 3, 5, 16'h0, 16'h5);
    run(4'h0, 16'h8202, 2'b00, 1, 5, 16'h0, 16'h0);
    // Divide-by-8 restarted mid-count: only the 8th tick after the write counts
    wb(1'b1, 4'h4, 4'h3, 32'h00008010);
    wb(1'b1, 4'hC, 4'h3, 32'h0);
    pulses(0, 4);
    wb(1'b1, 4'h4, 4'h3, 32'h00008010);
    pulses(0, 7);
    rdchk(4'hC, 32'h0);
    pulses(0, 1);
    rdchk(4'hC, 32'h1);
    $display("prescale restart case done");
    // Timer B left running on the internal clock must count only timer A wraps once joined
    wb(1'b1, 4'h4, 4'h3, 32'h00008000);
    wb(1'b1, 4'hC, 4'h3, 32'h0);
    wb(1'b1, 4'h8, 4'h3, 32'h0000FFFE);
    wb(1'b1, 4'h0, 4'h3, 32'h00008008);
    pulses(0, 4);
    rdchk(4'h8, 32'h2);
    rdchk(4'hC, 32'h1);
    chk({31'h0, join_wide_select_o}, 32'h1);
    chk(wraps_a, 32'h1);
    chk(wraps_b, 32'h1);
    $display("joined case done");
    complete_run();
  end
endmodule : paired_timer_control_bench
